// File: hdl/spi_config_loader.sv
// Serial-flash master configuration loader: straps, read frame, release
`default_nettype none

module spi_config_loader
    import spi_cfg_pkg::*;
#(
    parameter int ADDR_BITS = DEFAULT_ADDR_BITS
) (
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 clockEnable,
    input  wire logic                 linkClock,
    input  wire logic [MODE_W-1:0]    modePins,
    input  wire logic [VARIANT_W-1:0] readVariantSelect,
    input  wire logic [OPCODE_W-1:0]  strappedReadOpcode,
    input  wire logic                 initIn,
    output logic                      initOut,
    output logic                      initOutEn,
    input  wire logic                 doneIn,
    input  wire logic                 crcError,
    output logic                      configClockOut,
    output logic                      flashSelectN,
    output logic                      flashSelectNEn,
    output logic                      mosi,
    output logic                      mosiEn,
    input  wire logic                 flashDataIn,
    output logic                      daisyOut,
    output logic [OPCODE_W-1:0]       byteData,
    output logic                      byteStrobe,
    output logic                      configActive,
    output logic                      strapValid,
    output logic                      variantReserved
);

    // Command frame is the opcode followed by an all-zero start address
    localparam int FRAME_BITS = OPCODE_W + ADDR_BITS;
    localparam int CNT_W      = $clog2(FRAME_BITS + 1);
    localparam int PIN_W      = 1 + MODE_W + VARIANT_W + OPCODE_W;
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);
    localparam logic [2:0]       RX_LAST  = 3'h7;

    // Refuse address widths the frame shifter cannot hold
    if (ADDR_BITS < 0 || ADDR_BITS > 32 || (ADDR_BITS % 8) != 0) begin : g_chk
        $error("ADDR_BITS must be 0..32 in whole bytes");
    end

    // ---------------- Core clock domain ----------------

    strap_if straps ();                     // Captured straps and decode

    logic [PIN_W-1:0]      pinSync;         // Filtered pin levels
    logic                  initLevel;       // Filtered init pin
    logic [MODE_W-1:0]     modeLevel;       // Filtered mode pins
    logic [VARIANT_W-1:0]  variantLevel;    // Filtered variant pins
    logic [OPCODE_W-1:0]   strapLevel;      // Filtered address straps
    logic [1:0]            linkSync;        // Filtered done and byte toggle
    logic                  doneLevel;       // Filtered done pin
    logic                  byteTogLevel;    // Byte toggle seen in core

    logic                  initPrev_q;      // Init level one cycle back
    logic                  togPrev_q;       // Byte toggle one cycle back
    sys_state_t            state_q;         // Core sequencing state
    logic [MODE_W-1:0]     modeCap_q;       // Mode captured at init rise
    logic [VARIANT_W-1:0]  variantCap_q;    // Variant captured at init rise
    logic [OPCODE_W-1:0]   strapCap_q;      // Strap byte captured
    logic [OPCODE_W-1:0]   opcode_q;        // Opcode held for the link
    logic                  startReq_q;      // Level asking link to start
    logic                  stopReq_q;       // Level asking link to stop
    logic                  initDrive_q;     // Init pin is driven low
    logic                  initOut_q;       // Init output level
    logic [OPCODE_W-1:0]   byteData_q;      // Last byte handed to core
    logic                  byteStrobe_q;    // One-cycle byte pulse
    logic                  configActive_q;  // Loading in progress
    logic                  strapValid_q;    // Straps have been taken
    logic                  reserved_q;      // Variant was the reserved code
    logic                  initRise;        // Init pin rose this cycle

    // Link-side registers read by the core through the crossing
    logic                  byteToggle_q;    // Flips once per received byte
    logic [OPCODE_W-1:0]   byteHold_q;      // Byte held stable for core

    // Init is sampled through the same filter as the straps, so the
    // straps are taken on the very edge that the init rise is seen.
    pin_sync #(.W(PIN_W)) uPinSync (
        .clock (clock),
        .rstn  (rstn),
        .d     ({initIn, modePins, readVariantSelect, strappedReadOpcode}),
        .q     (pinSync)
    );
    assign {initLevel, modeLevel, variantLevel, strapLevel} = pinSync;

    // Done pin and the link's byte toggle enter the core domain
    pin_sync #(.W(2)) uLinkSync (
        .clock (clock),
        .rstn  (rstn),
        .d     ({doneIn, byteToggle_q}),
        .q     (linkSync)
    );
    assign {doneLevel, byteTogLevel} = linkSync;

    // Captured straps feed the opcode decoder
    assign straps.mode        = modeCap_q;
    assign straps.variant     = variantCap_q;
    assign straps.strapOpcode = strapCap_q;

    opcode_select uDecode (
        .straps (straps)
    );

    // Reset clears the previous level, so a pin already high at release
    // counts as a rise and configuration starts by itself.
    assign initRise = initLevel && !initPrev_q;

    // Edge history of init and byte toggle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            initPrev_q <= 1'b0;
            togPrev_q  <= 1'b0;
        end else if (clockEnable) begin
            initPrev_q <= initLevel;
            togPrev_q  <= byteTogLevel;
        end
    end

    // Strap capture: one shot, on the first init rise after reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            modeCap_q    <= '0;
            variantCap_q <= '0;
            strapCap_q   <= '0;
            strapValid_q <= 1'b0;
        end else if (clockEnable && state_q == S_WAIT_INIT && initRise) begin
            modeCap_q    <= modeLevel;
            variantCap_q <= variantLevel;
            strapCap_q   <= strapLevel;
            strapValid_q <= 1'b1;
        end
    end

    // Core sequencer; held in reset or with init low, nothing starts
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q    <= S_WAIT_INIT;
            startReq_q <= 1'b0;
            stopReq_q  <= 1'b0;
            opcode_q   <= '0;
            reserved_q <= 1'b0;
        end else if (clockEnable) begin
            unique case (state_q)
                S_WAIT_INIT: begin
                    // Decode runs a cycle after capture, so wait on valid
                    if (strapValid_q) begin
                        reserved_q <= straps.reserved;
                        if (straps.masterMode && !straps.reserved) begin
                            opcode_q   <= straps.opcode;
                            startReq_q <= 1'b1;
                            state_q    <= S_LOADING;
                        end else begin
                            // Not our mode, or no opcode: stay off the bus
                            state_q <= S_HALTED;
                        end
                    end
                end
                S_LOADING: begin
                    if (doneLevel) begin
                        stopReq_q <= 1'b1;
                        state_q   <= S_DONE;
                    end
                end
                S_DONE:   state_q <= S_DONE;
                S_HALTED: state_q <= S_HALTED;
                default:  state_q <= S_HALTED;
            endcase
        end
    end

    // Init pin turns into an open-drain error flag once straps are taken;
    // the flag is sticky until the next full reset.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            initDrive_q <= 1'b0;
            initOut_q   <= 1'b0;
        end else if (clockEnable) begin
            initOut_q <= 1'b0;
            if (strapValid_q && crcError) begin
                initDrive_q <= 1'b1;
            end
        end
    end

    // Received bytes: data was held stable long before the toggle is seen here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            byteData_q   <= '0;
            byteStrobe_q <= 1'b0;
        end else if (clockEnable) begin
            byteStrobe_q <= 1'b0;
            // Bytes after done are dropped; the frame is being closed
            if (byteTogLevel != togPrev_q && state_q == S_LOADING) begin
                byteData_q   <= byteHold_q;
                byteStrobe_q <= 1'b1;
            end
        end
    end

    // Status flags shown to the rest of the chip
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            configActive_q <= 1'b0;
        end else if (clockEnable) begin
            configActive_q <= (state_q == S_LOADING);
        end
    end

    assign initOut         = initOut_q;
    assign initOutEn       = initDrive_q;
    assign byteData        = byteData_q;
    assign byteStrobe      = byteStrobe_q;
    assign configActive    = configActive_q;
    assign strapValid      = strapValid_q;
    assign variantReserved = reserved_q;

    // ---------------- Link clock domain ----------------

    logic [1:0]            linkRst_q;       // Reset release synchroniser
    logic                  linkRstn;        // Link-domain reset
    logic [2:0]            ctlSync;         // Filtered enable, start, stop
    logic                  ceLink;          // Clock enable in link domain
    logic                  startLink;       // Start request seen
    logic                  stopLink;        // Stop request seen
    link_state_t           lstate_q;        // Frame state
    logic                  config_clock_out_q;          // Clock driven to the flash
    logic                  selN_q;          // Chip select, low active
    logic                  selEn_q;         // Chip select drive enable
    logic                  mosi_q;          // Command output bit
    logic                  mosiEn_q;        // Command output enable
    logic [FRAME_BITS-1:0] shift_q;         // Command bits still to send
    logic [CNT_W-1:0]      bitCnt_q;        // Command bits left
    logic [OPCODE_W-1:0]   rxShift_q;       // Incoming bits
    logic [2:0]            rxCnt_q;         // Bits in the current byte
    logic                  daisy_q;         // Bit passed down the chain
    logic                  fallStep;        // This edge takes the clock low

    // Assertion is immediate, release waits two link edges
    always_ff @(posedge linkClock or negedge rstn) begin
        if (!rstn) begin
            linkRst_q <= 2'h0;
        end else begin
            linkRst_q <= {linkRst_q[0], 1'b1};
        end
    end
    assign linkRstn = linkRst_q[1];

    // Core levels enter the link domain; opcode_q is stable by then
    pin_sync #(.W(3)) uCtlSync (
        .clock (linkClock),
        .rstn  (linkRstn),
        .d     ({clockEnable, startReq_q, stopReq_q}),
        .q     (ctlSync)
    );
    assign {ceLink, startLink, stopLink} = ctlSync;

    assign fallStep = config_clock_out_q;

    // Frame sequencer: the flash clock is the link clock divided by two,
    // so each half period is one link cycle.
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            lstate_q <= L_IDLE;
            config_clock_out_q   <= CLOCK_IDLE;
            selN_q   <= SELECT_IDLE_N;
            selEn_q  <= 1'b0;
            mosi_q   <= 1'b1;
            mosiEn_q <= 1'b0;
            shift_q  <= '0;
            bitCnt_q <= '0;
        end else if (ceLink) begin
            unique case (lstate_q)
                L_IDLE: begin
                    if (startLink) begin
                        // Clock falls, select drops, first bit appears
                        config_clock_out_q   <= 1'b0;
                        selN_q   <= 1'b0;
                        selEn_q  <= 1'b1;
                        mosiEn_q <= 1'b1;
                        mosi_q   <= opcode_q[OPCODE_W-1];
                        shift_q  <= {opcode_q, {ADDR_BITS{1'b0}}} << 1;
                        bitCnt_q <= LAST_BIT;
                        lstate_q <= L_CMD;
                    end
                end
                L_CMD: begin
                    config_clock_out_q <= !config_clock_out_q;
                    if (fallStep) begin
                        if (bitCnt_q == '0) begin
                            mosi_q   <= 1'b0;
                            lstate_q <= L_READ;
                        end else begin
                            mosi_q   <= shift_q[FRAME_BITS-1];
                            shift_q  <= shift_q << 1;
                            bitCnt_q <= bitCnt_q - 1'b1;
                        end
                    end
                end
                L_READ: begin
                    // Select stays low and the clock runs without a gap
                    if (fallStep && stopLink) begin
                        config_clock_out_q   <= 1'b0;
                        selN_q   <= 1'b1;
                        lstate_q <= L_STOP;
                    end else begin
                        config_clock_out_q <= !config_clock_out_q;
                    end
                end
                L_STOP: begin
                    // Pins are let go to the pull-ups and user logic
                    selEn_q  <= 1'b0;
                    mosiEn_q <= 1'b0;
                end
            endcase
        end
    end

    // Receive path: flash data is launched off our own clock, so it is
    // taken directly at the rising step, not through a synchroniser.
    always_ff @(posedge linkClock or negedge linkRstn) begin
        if (!linkRstn) begin
            rxShift_q    <= '0;
            rxCnt_q      <= '0;
            byteHold_q   <= '0;
            byteToggle_q <= 1'b0;
            daisy_q      <= 1'b0;
        end else if (ceLink && lstate_q == L_READ && !fallStep) begin
            rxShift_q <= {rxShift_q[OPCODE_W-2:0], flashDataIn};
            // Same stream is passed on to slave devices down the chain
            daisy_q   <= flashDataIn;
            rxCnt_q   <= rxCnt_q + 1'b1;
            if (rxCnt_q == RX_LAST) begin
                byteHold_q   <= {rxShift_q[OPCODE_W-2:0], flashDataIn};
                byteToggle_q <= !byteToggle_q;
            end
        end
    end

    assign configClockOut = config_clock_out_q;
    assign flashSelectN   = selN_q;
    assign flashSelectNEn = selEn_q;
    assign mosi           = mosi_q;
    assign mosiEn         = mosiEn_q;
    assign daisyOut       = daisy_q;

endmodule : spi_config_loader

`default_nettype wire

// File: shared/spi_cfg_pkg.sv
// Constants, codes and state types of the serial-flash configuration loader
//
// Function
// - Variant pins pick the flash read opcode
// - Variant 001 captures opcode from address straps
// - Stop reading flash once done goes high
// - Release select and data-out pins after done
// - Start configuring by itself after power-on
// - Drop chip select, then shift read command
// - Held reset delays configuration until released
// - Held-low init pin postpones configuration start
// - Chain leader is flash master, others slaves
// - All chain bitstreams come from one flash
// - Mode pins 001 select serial-flash master
// - Select and command change on clock fall
// - Flash data sampled on clock rise
// - Init drives low on CRC error afterwards
`default_nettype none

package spi_cfg_pkg;

    // Field widths of the strap inputs, sync depth and default address width
    localparam int OPCODE_W    = 8;
    localparam int MODE_W      = 3;
    localparam int VARIANT_W   = 3;
    localparam int SYNC_STAGES = 3;
    localparam int DEFAULT_ADDR_BITS = 24;

    // Mode pin code for serial-flash master configuration
    localparam logic [MODE_W-1:0] MODE_FLASH_MASTER = 3'h1;

    // Variant pin codes
    localparam logic [VARIANT_W-1:0] VAR_OPC_FF  = 3'h0;
    localparam logic [VARIANT_W-1:0] VAR_STRAP   = 3'h1;
    localparam logic [VARIANT_W-1:0] VAR_OPC_52  = 3'h2;
    localparam logic [VARIANT_W-1:0] VAR_RESERVED = 3'h3;
    localparam logic [VARIANT_W-1:0] VAR_OPC_55  = 3'h4;
    localparam logic [VARIANT_W-1:0] VAR_OPC_03  = 3'h5;
    localparam logic [VARIANT_W-1:0] VAR_OPC_E8  = 3'h6;
    localparam logic [VARIANT_W-1:0] VAR_OPC_0B  = 3'h7;

    // Read opcodes issued for each fixed variant
    localparam logic [OPCODE_W-1:0] OPC_FF = 8'hff;
    localparam logic [OPCODE_W-1:0] OPC_52 = 8'h52;
    localparam logic [OPCODE_W-1:0] OPC_55 = 8'h55;
    localparam logic [OPCODE_W-1:0] OPC_03 = 8'h03;
    localparam logic [OPCODE_W-1:0] OPC_E8 = 8'he8;
    localparam logic [OPCODE_W-1:0] OPC_0B = 8'h0b;

    // Reset values of the flash-side pins
    localparam logic SELECT_IDLE_N = 1'b1;
    localparam logic CLOCK_IDLE    = 1'b1;

    // Core-side sequencing states
    typedef enum logic [2:0] {
        S_WAIT_INIT = 3'b000,
        S_LOADING   = 3'b001,
        S_DONE      = 3'b010,
        S_HALTED    = 3'b011
    } sys_state_t;

    // Link-side frame states
    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_CMD  = 2'b01,
        L_READ = 2'b10,
        L_STOP = 2'b11
    } link_state_t;

endpackage : spi_cfg_pkg

`default_nettype wire

// File: shared/strap_if.sv
// Captured straps and the decoded read opcode between loader and decoder
`default_nettype none

interface strap_if;
    import spi_cfg_pkg::*;

    logic [MODE_W-1:0]    mode;        // Captured mode pins
    logic [VARIANT_W-1:0] variant;     // Captured variant pins
    logic [OPCODE_W-1:0]  strapOpcode; // Captured address-strap byte
    logic [OPCODE_W-1:0]  opcode;      // Decoded read opcode
    logic                 reserved;    // Variant code has no opcode
    logic                 masterMode;  // Mode selects flash master

    modport owner   (output mode, output variant, output strapOpcode,
                     input opcode, input reserved, input masterMode);
    modport decoder (input mode, input variant, input strapOpcode,
                     output opcode, output reserved, output masterMode);
endinterface : strap_if

`default_nettype wire

// File: hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for foreign inputs
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import spi_cfg_pkg::*;

    // Stage one is read only by stage two
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;

    // Plain shift chain; no enable so a frozen block still tracks pins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= d;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // A bit changes only once stages two and three agree; each bit keeps
    // its own flop so that no output bit has two procedural writers
    genvar i;
    for (i = 0; i < W; i++) begin : g_agree
        logic agree_q;  // Filtered level of this bit
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                agree_q <= 1'b0;
            end else if (stage2_q[i] == stage3_q[i]) begin
                agree_q <= stage3_q[i];
            end
        end
        assign q[i] = agree_q;
    end
endmodule : pin_sync

`default_nettype wire

// File: hdl/opcode_select.sv
// Decodes captured straps into the flash read opcode
`default_nettype none

module opcode_select (
    strap_if.decoder straps
);
    import spi_cfg_pkg::*;

    // Table lookup of the read opcode by variant code
    always_comb begin
        straps.reserved = 1'b0;
        unique case (straps.variant)
            VAR_OPC_FF:   straps.opcode = OPC_FF;
            VAR_STRAP:    straps.opcode = straps.strapOpcode;
            VAR_OPC_52:   straps.opcode = OPC_52;
            VAR_RESERVED: begin
                // Nothing is issued for the reserved code
                straps.opcode   = OPC_FF;
                straps.reserved = 1'b1;
            end
            VAR_OPC_55:   straps.opcode = OPC_55;
            VAR_OPC_03:   straps.opcode = OPC_03;
            VAR_OPC_E8:   straps.opcode = OPC_E8;
            VAR_OPC_0B:   straps.opcode = OPC_0B;
        endcase
    end

    // Only this mode code makes us the flash master
    always_comb begin
        straps.masterMode = (straps.mode == MODE_FLASH_MASTER);
    end
endmodule : opcode_select

`default_nettype wire

// File: testbench/spi_cfg_assertions.sv
// Checker on the pins of the serial-flash configuration loader
`default_nettype none

module spi_cfg_assertions (
    input wire logic clock,
    input wire logic rstn,
    input wire logic linkClock,
    input wire logic crcError,
    input wire logic initOut,
    input wire logic initOutEn,
    input wire logic configClockOut,
    input wire logic flashSelectN,
    input wire logic flashSelectNEn,
    input wire logic mosi,
    input wire logic mosiEn,
    input wire logic byteStrobe,
    input wire logic strapValid,
    input wire logic variantReserved
);
    // One flash clock period: a fall followed by a rise
    sequence clkToggle;
        $fell(configClockOut) ##1 $rose(configClockOut);
    endsequence
    // Frame start drives both pins at once
    sequence frameOpen;
        flashSelectNEn && mosiEn;
    endsequence

    sel_on_fall_a: assert property (@(posedge linkClock) disable iff (!rstn)
        $changed(flashSelectN) |-> $fell(configClockOut)) else $error("select moved off fall");
    mosi_on_fall_a: assert property (@(posedge linkClock) disable iff (!rstn)
        mosiEn && $changed(mosi) |-> $fell(configClockOut)) else $error("mosi moved off fall");
    frame_open_a: assert property (@(posedge linkClock) disable iff (!rstn)
        $fell(flashSelectN) |-> frameOpen) else $error("select low undriven");
    clock_runs_a: assert property (@(posedge linkClock) disable iff (!rstn)
        !flashSelectN && $fell(configClockOut) |-> clkToggle) else $error("clock stalled");
    idle_clock_a: assert property (@(posedge linkClock) disable iff (!rstn)
        !flashSelectNEn && !$past(flashSelectNEn) |-> $stable(configClockOut))
        else $error("clock moved while idle");
    no_early_sel_a: assert property (@(posedge clock) disable iff (!rstn)
        !strapValid |-> flashSelectN && !flashSelectNEn) else $error("select before start");
    reserved_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
        variantReserved |-> !flashSelectNEn && !mosiEn) else $error("reserved variant ran");
    strobe_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
        byteStrobe |=> !byteStrobe) else $error("strobe too long");
    crc_init_a: assert property (@(posedge clock) disable iff (!rstn)
        strapValid && crcError |=> initOutEn && !initOut) else $error("crc not flagged");
    init_sticky_a: assert property (@(posedge clock) disable iff (!rstn)
        initOutEn |=> initOutEn) else $error("init drive dropped");
endmodule : spi_cfg_assertions

bind spi_config_loader spi_cfg_assertions i_spi_cfg_assertions (.*);

`default_nettype wire

// File: testbench/flash_model.sv
// Behavioural serial flash answering the loader's read frame
`default_nettype none

module flash_model (
    input  wire logic       sck,
    input  wire logic       selN,
    input  wire logic       si,
    input  wire logic       ready,
    output logic            so,
    output logic [7:0]      opcode,
    output int              cmdBits,
    output logic            earlySel
);
    timeunit 1ns;
    timeprecision 1ps;
    int         outBits;   // Data bits sent in this frame
    logic [7:0] outByte;   // Byte now being shifted out
    initial begin
        cmdBits = 0;
        outBits = 0;
        earlySel = 0;
        so = 1'b1;
    end
    // Deselect ends the frame; the next one starts afresh
    always @(posedge selN) begin
        cmdBits = 0;
        outBits = 0;
    end
    // Selecting before power-up is complete is flagged
    always @(negedge selN) if (!ready) earlySel = 1'b1;
    // Command bits taken on the rising clock, opcode first
    always @(posedge sck) if (!selN && cmdBits < 32) begin
        if (cmdBits < 8) opcode = {opcode[6:0], si};
        cmdBits++;
    end
    // One continuous stream for the whole chain; pulled up if idle
    always @(negedge sck or posedge selN) begin
        outByte = 8'h3c + outBits[10:3];
        so = 1'b1;
        if (!selN && cmdBits == 32) begin
            so = outByte[3'h7 - outBits[2:0]];
            outBits++;
        end
    end
endmodule : flash_model

`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the serial-flash configuration loader
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, linkClock = 0, clockEnable = 1, doneIn = 0;
    logic crcError = 0, flashReady = 0, initHold = 0, so;
    logic [2:0] modePins = 3'h1, readVariantSelect = 3'h0;
    logic [7:0] strappedReadOpcode = 8'ha7, byteData, opcode;
    logic initOut, initOutEn, configClockOut, flashSelectN, flashSelectNEn;
    logic mosi, mosiEn, daisyOut, byteStrobe, configActive, strapValid;
    logic variantReserved, earlySel;
    int error_cnt = 0, comparisons = 0, cycles = 0, cmdBits, n;
    logic [7:0] expOpc [8] = '{8'hff, 8'ha7, 8'h52, 8'h00,
                               8'h55, 8'h03, 8'he8, 8'h0b};
    // Open-drain and pulled-up pin levels seen by every party
    wire initLine = initHold & (initOutEn ? initOut : 1'b1);
    wire selPin   = flashSelectNEn ? flashSelectN : 1'b1;
    wire mosiPin  = mosiEn ? mosi : 1'b1;

    spi_config_loader i_spi_config_loader (.*, .initIn(initLine),
        .flashDataIn(so));
    flash_model i_flash_model (.sck(configClockOut), .selN(selPin),
        .si(mosiPin), .ready(flashReady), .so(so), .opcode(opcode),
        .cmdBits(cmdBits), .earlySel(earlySel));

    initial forever #5 clock = ~clock;
    initial begin
        #7;
        forever #24 linkClock = ~linkClock;
    end
    // Cut a hang short
    always @(posedge clock) if (++cycles == 30000) begin
        error_cnt++;
        complete_run();
    end

    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    task wait_strobe;
        n = 0;
        do begin @(negedge clock); n++; end while (!byteStrobe && n < 900);
    endtask : wait_strobe

    // One power-up: straps, delayed init, frame, done, release
    task run(input logic [2:0] m, input logic [2:0] v, input logic [7:0] opc);
        rstn = 0;
        initHold = 0;
        flashReady = 0;
        doneIn = 0;
        modePins = m;
        readVariantSelect = v;
        repeat (10) @(negedge clock);
        rstn = 1;
        repeat (30) @(negedge clock);
        check(selPin, 1);
        flashReady = 1;
        initHold = 1;
        repeat (20) @(negedge clock);
        check(variantReserved, v == 3'h3);
        if (m != 3'h1 || v == 3'h3) begin
            repeat (200) @(negedge clock);
            check(cmdBits, 0);
            return;
        end
        n = 0;
        while (cmdBits < 32 && n < 900) begin @(negedge clock); n++; end
        check(opcode, opc);
        wait_strobe();
        check(byteData, 8'h3c);
        wait_strobe();
        check(byteData, 8'h3d);
        check({configActive, daisyOut}, 3);
        doneIn = 1;
        repeat (60) @(negedge clock);
        check({flashSelectNEn, mosiEn, configActive}, 0);
        wait_strobe();
        check(n == 900, 1);
    endtask : run

    initial begin
        for (int i = 0; i < 8; i++) run(3'h1, i[2:0], expOpc[i]);
        crcError = 1;
        @(negedge clock);
        crcError = 0;
        @(negedge clock);
        check(initLine, 0);
        run(3'h2, 3'h5, 8'h00);
        check(earlySel, 0);
        complete_run();
    end

    task complete_run;
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
endmodule : testbench

`default_nettype wire
